// file: shared/vib_regs_map.svh
`ifndef VIB_REGS_MAP_SVH
`define VIB_REGS_MAP_SVH

// bus address of the device, 7 bits, r/w bit follows
`define DEV_ADDR 7'h06

// register offsets
`define OFS_DRIVE_MODE 8'h20
`define OFS_DRIVE_SETTING 8'h21
`define OFS_HEALTH_FLAGS 8'h22

// reset values
`define RST_DRIVE_MODE 8'h90
`define RST_DRIVE_SETTING 8'h2C
`define RST_HEALTH_FLAGS 8'h0E

// writable bits of each writable register
`define WMASK_DRIVE_MODE 8'hE0
`define WMASK_DRIVE_SETTING 8'hFC

// field positions, drive_mode register
`define POS_DRIVE_EN 7
`define POS_BOOST_EN 6
`define POS_BOOST_HIGH 5

// field positions, drive_setting register
`define MSB_INPUT_RES 7
`define LSB_INPUT_RES 5
`define MSB_LEVEL 4
`define LSB_LEVEL 2

// field positions, health_flags register
`define POS_SUPPLY_GOOD 3
`define POS_REG_GOOD 2
`define POS_OVERTEMP_OK 1

// level code that names no voltage
`define LEVEL_UNDEFINED 3'h7

// bits per byte on the serial bus
`define BITS_PER_BYTE 4'h8

`endif

// file: shared/vib_regs_pkg.sv
package vib_regs_pkg;

   // serial slave states
   typedef enum logic [3:0] {
      st_idle,
      st_addr,
      st_ack_addr,
      st_ptr,
      st_ack_ptr,
      st_wdata,
      st_ack_w,
      st_rdata,
      st_ack_r
   } ser_state_t;

   // analog monitor levels, as seen by the logic
   typedef struct packed {
      logic supply_good;
      logic reg_good;
      logic temp_above_hi;
      logic temp_below_lo;
   } monitor_t;

   // settings handed to the analog drive stage
   typedef struct packed {
      logic drive_enable;
      logic boost_drive_enable;
      logic boost_high_side;
      logic [2:0] input_res_select;
      logic [2:0] drive_level_select;
      logic level_undefined;
   } drive_cfg_t;

endpackage : vib_regs_pkg

// file: core/vib_regs.sv
// Notes on behaviour
// - drive_setting bits 7:5 pick input resistance 8..22 kohm; register resets 0x2C.
// - drive_setting bits 4:2 pick drive level 2.4..3.6 V; code 7 undefined.
// - health_flags is read-only, resets 0x0E; bits 7:4 and 0 read zero.
// - health bit 3 is 1 while supply is above undervoltage lockout.
// - health bit 2 is 0 while regulator output below 70 percent.
// - health bit 1 is 0 while over-temperature protection is tripped.
// - above 150 C drive shuts down, stays off until below 134 C.
// - host-written register contents survive a thermal shutdown untouched.
// - every register field takes its default at power-up, before bus traffic.
// - device runs fully on defaults with serial lines left floating.
// - defaults: drive enabled, boost off, 10 kohm input, 3.0 V level.
// - both motor outputs grounded while run input low; driven while high if drive enabled, supply good and not hot.
// - device answers only bus address 0000110 plus read/write bit.
// - pointer increments after each byte in multi-byte reads and writes.
`timescale 1ns/1ps
`include "vib_regs_map.svh"

module vib_regs
   import vib_regs_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire monitor_t monitor,
   input wire logic motor_run_input,
   output logic motor_out_pos,
   output logic motor_out_neg,
   output drive_cfg_t drive_cfg,
   output logic thermal_shutdown
);

   // serial line samples and edges
   logic scl_q_r;
   logic sda_q_r;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // serial slave state
   ser_state_t state_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] tx_r;
   logic [7:0] ptr_r;
   logic rw_r;
   logic master_ack_r;

   // registers
   logic [7:0] drive_mode_r;
   logic [7:0] drive_setting_r;
   logic [7:0] health_flags_r;
   logic shutdown_r;
   logic [7:0] read_data;
   logic [7:0] ptr_nxt;
   logic drive_ok;

   // output flops
   logic sda_oe_r;
   logic sda_out_r;
   logic motor_pos_r;
   logic motor_neg_r;
   drive_cfg_t drive_cfg_r;

   // lines are taken as synchronous, so one flop each is enough
   // remember last level of both lines to find edges and start/stop
   always_ff @(posedge clk) begin
      if (!nrst) begin
         scl_q_r <= 1'b1; // floating lines idle high
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_in;
         sda_q_r <= sda_in;
      end
   end

   // start and stop need scl high on both samples, so a lone scl glitch fakes neither
   // line events; a floating bus never makes a start, so defaults stay
   assign scl_rise = scl_in && !scl_q_r;
   assign scl_fall = !scl_in && scl_q_r;
   assign start_seen = scl_in && scl_q_r && sda_q_r && !sda_in;
   assign stop_seen = scl_in && scl_q_r && !sda_q_r && sda_in;

   // read data follows the pointer; it is taken as each read byte begins
   // register read selection; unmapped offsets read zero, as do unused bits except drive_mode bit 4, which resets to 1
   always_comb begin
      unique case (ptr_r)
         `OFS_DRIVE_MODE: read_data = drive_mode_r;
         `OFS_DRIVE_SETTING: read_data = drive_setting_r;
         `OFS_HEALTH_FLAGS: read_data = health_flags_r;
         default: read_data = 8'h00;
      endcase
   end

   assign ptr_nxt = ptr_r + 8'h01;

   // no clock stretching: each scl phase must last three clocks or more
   // serial slave: bits sampled on scl rise, sda changed on scl fall
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_r <= st_idle;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         rw_r <= 1'b0;
         master_ack_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (stop_seen) begin
         state_r <= st_idle;
         sda_oe_r <= 1'b0;
      end else if (start_seen) begin
         // repeated start lands here too and begins a fresh address byte
         state_r <= st_addr;
         bit_cnt_r <= 4'h0;
         sda_oe_r <= 1'b0;
      end else begin
         unique case (state_r)
            st_idle: begin
               sda_oe_r <= 1'b0;
            end
            st_addr, st_ptr, st_wdata: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_in};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall && bit_cnt_r == `BITS_PER_BYTE) begin
                  bit_cnt_r <= 4'h0;
                  if (state_r == st_addr) begin
                     if (shift_r[7:1] == `DEV_ADDR) begin
                        rw_r <= shift_r[0];
                        sda_oe_r <= 1'b1;
                        state_r <= st_ack_addr;
                     end else begin
                        state_r <= st_idle; // not ours: stay off the bus
                     end
                  end else begin
                     sda_oe_r <= 1'b1;
                     state_r <= (state_r == st_ptr) ? st_ack_ptr : st_ack_w;
                  end
               end
            end
            st_ack_addr: begin
               if (scl_fall) begin
                  if (rw_r) begin
                     // first read bit goes out as the ack clock ends
                     tx_r <= read_data;
                     sda_oe_r <= !read_data[7];
                     state_r <= st_rdata;
                     bit_cnt_r <= 4'h1;
                  end else begin
                     sda_oe_r <= 1'b0;
                     state_r <= st_ptr;
                  end
               end
            end
            st_ack_ptr, st_ack_w: begin
               if (scl_fall) begin
                  sda_oe_r <= 1'b0;
                  state_r <= st_wdata;
               end
            end
            st_rdata: begin
               if (scl_fall) begin
                  if (bit_cnt_r == `BITS_PER_BYTE) begin
                     sda_oe_r <= 1'b0; // release for the master's ack
                     bit_cnt_r <= 4'h0;
                     state_r <= st_ack_r;
                  end else begin
                     sda_oe_r <= !tx_r[3'(7 - bit_cnt_r)];
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
            end
            st_ack_r: begin
               if (scl_rise) begin
                  master_ack_r <= !sda_in;
               end else if (scl_fall) begin
                  if (master_ack_r) begin
                     // pointer has already moved on; send next register
                     tx_r <= read_data;
                     sda_oe_r <= !read_data[7];
                     bit_cnt_r <= 4'h1;
                     state_r <= st_rdata;
                  end else begin
                     state_r <= st_idle; // nack: wait for stop
                  end
               end
            end
         endcase
      end
   end

   // open-drain data line only ever pulls low
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sda_out_r <= 1'b0;
      end else begin
         sda_out_r <= 1'b0;
      end
   end

   // a byte cut short by start or stop moves nothing
   // pointer: loaded by the pointer byte, stepped after each data byte
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ptr_r <= 8'h00;
      end else if (!stop_seen && !start_seen && scl_fall) begin
         if (state_r == st_ptr && bit_cnt_r == `BITS_PER_BYTE) begin
            ptr_r <= shift_r;
         end else if (state_r == st_wdata && bit_cnt_r == `BITS_PER_BYTE) begin
            ptr_r <= ptr_nxt;
         end else if (state_r == st_rdata && bit_cnt_r == `BITS_PER_BYTE) begin
            ptr_r <= ptr_nxt;
         end
      end
   end

   // unused bits are masked on the way in, so they read back zero
   // writable registers; only reset and the bus change them
   always_ff @(posedge clk) begin
      if (!nrst) begin
         drive_mode_r <= `RST_DRIVE_MODE;
         drive_setting_r <= `RST_DRIVE_SETTING;
      end else if (!stop_seen && !start_seen && scl_fall && state_r == st_wdata
                   && bit_cnt_r == `BITS_PER_BYTE) begin
         // no thermal term here, settings outlive a shutdown
         unique case (ptr_r)
            `OFS_DRIVE_MODE: drive_mode_r <= shift_r & `WMASK_DRIVE_MODE;
            `OFS_DRIVE_SETTING: drive_setting_r <= shift_r & `WMASK_DRIVE_SETTING;
            default: ;
         endcase
      end
   end

   // set wins over clear, so a hot die never slips through a release
   // thermal latch with hysteresis between the two comparators
   always_ff @(posedge clk) begin
      if (!nrst) begin
         shutdown_r <= 1'b0;
      end else if (monitor.temp_above_hi) begin
         shutdown_r <= 1'b1;
      end else if (monitor.temp_below_lo) begin
         shutdown_r <= 1'b0;
      end
   end

   // live, not sticky: supply and regulator flags recover as soon as their monitors do; bit 1 waits for the thermal latch to clear
   // status flags follow the monitors; the bus never writes them
   always_ff @(posedge clk) begin
      if (!nrst) begin
         health_flags_r <= `RST_HEALTH_FLAGS;
      end else begin
         health_flags_r <= 8'h00;
         health_flags_r[`POS_SUPPLY_GOOD] <= monitor.supply_good;
         health_flags_r[`POS_REG_GOOD] <= monitor.reg_good;
         health_flags_r[`POS_OVERTEMP_OK] <= !shutdown_r && !monitor.temp_above_hi;
      end
   end

   // faults that ground the bridge; the raw hot flag counts too,
   // so the legs drop in the same clock as the latch sets
   assign drive_ok = drive_mode_r[`POS_DRIVE_EN] && !shutdown_r && !monitor.temp_above_hi
                     && monitor.supply_good;

   // bridge drive; both legs share one enable, the analog stage picks polarity
   always_ff @(posedge clk) begin
      if (!nrst) begin
         motor_pos_r <= 1'b0;
         motor_neg_r <= 1'b0;
      end else begin
         motor_pos_r <= motor_run_input && drive_ok;
         motor_neg_r <= motor_run_input && drive_ok;
      end
   end

   // one clock behind the registers; the analog stage settles far slower
   // settings to the analog stage, registered once more
   always_ff @(posedge clk) begin
      if (!nrst) begin
         drive_cfg_r <= '0;
      end else begin
         drive_cfg_r.drive_enable <= drive_mode_r[`POS_DRIVE_EN];
         drive_cfg_r.boost_drive_enable <= drive_mode_r[`POS_BOOST_EN];
         drive_cfg_r.boost_high_side <= drive_mode_r[`POS_BOOST_HIGH];
         drive_cfg_r.input_res_select <= drive_setting_r[`MSB_INPUT_RES:`LSB_INPUT_RES];
         drive_cfg_r.drive_level_select <= drive_setting_r[`MSB_LEVEL:`LSB_LEVEL];
         // code 7 is flagged so the regulator can hold its last level
         drive_cfg_r.level_undefined <= drive_setting_r[`MSB_LEVEL:`LSB_LEVEL] == `LEVEL_UNDEFINED;
      end
   end

   // every output comes straight from its flop
   assign sda_oe = sda_oe_r;
   assign sda_out = sda_out_r;
   assign motor_out_pos = motor_pos_r;
   assign motor_out_neg = motor_neg_r;
   assign drive_cfg = drive_cfg_r;
   assign thermal_shutdown = shutdown_r;

endmodule : vib_regs

// file: verif/vib_regs_asserts.sv
`timescale 1ns/1ps
module vib_regs_asserts
   import vib_regs_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire monitor_t monitor,
   input wire logic motor_run_input,
   input wire logic motor_out_pos,
   input wire logic motor_out_neg,
   input wire drive_cfg_t drive_cfg,
   input wire logic thermal_shutdown
);
   // one domain, so clock and reset are given once
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_motor_idle: assert property (!motor_run_input |=> !motor_out_pos && !motor_out_neg)
      else $error("motor driven while idle");
   a_motor_pair: assert property (motor_out_pos == motor_out_neg)
      else $error("motor legs disagree");
   a_motor_run: assert property (motor_run_input && monitor.supply_good && !monitor.temp_above_hi
      && !thermal_shutdown |=> motor_out_pos == drive_cfg.drive_enable)
      else $error("motor not driven");
   a_hot_stop: assert property (monitor.temp_above_hi |=> !motor_out_pos)
      else $error("motor driven while hot");
   a_shut_set: assert property (monitor.temp_above_hi |=> thermal_shutdown)
      else $error("shutdown not latched");
   a_shut_hold: assert property (thermal_shutdown && !monitor.temp_below_lo |=> thermal_shutdown)
      else $error("shutdown released early");
   a_undef_flag: assert property (drive_cfg.level_undefined == (drive_cfg.drive_level_select == 3'h7))
      else $error("undefined level flag wrong");
   a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("data pulled while bus clock high");
   a_reset_dflt: assert property ($rose(nrst) |-> ##2 drive_cfg == 10'h216)
      else $error("defaults not loaded");
endmodule : vib_regs_asserts

bind vib_regs vib_regs_asserts u_chk (.clk, .nrst, .scl_in, .sda_in, .sda_out, .sda_oe, .monitor,
   .motor_run_input, .motor_out_pos, .motor_out_neg, .drive_cfg, .thermal_shutdown);

// file: verif/i2c_host_model.sv
`timescale 1ns/1ps
`include "vib_regs_map.svh"
module i2c_host_model (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda
);
   // released bus idles high through the pull-up
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // one bus clock phase, four clocks, moved just after the edge
   task h;
      repeat (4) @(posedge clk);
      #1;
   endtask : h
   // also a repeated start: sda rises while scl is still low
   task start;
      sda = 1'b1;
      h();
      scl = 1'b1;
      h();
      sda = 1'b0;
      h();
      scl = 1'b0;
      h();
   endtask : start
   task stop;
      sda = 1'b0;
      h();
      scl = 1'b1;
      h();
      sda = 1'b1;
      h();
   endtask : stop
   // data changes only one phase after scl fell, halfway through the low time
   task bit_io(input logic b, output logic s);
      sda = b;
      h();
      scl = 1'b1;
      h();
      s = sda_line;
      scl = 1'b0;
      h();
   endtask : bit_io
   task send(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(v[i], s);
      bit_io(1'b1, s);
      ack = (s === 1'b0);
   endtask : send
   task recv(input logic more, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(!more, s);
      sda = 1'b1;
   endtask : recv
   task addr(input logic rw, output logic ack);
      send({`DEV_ADDR, rw}, ack);
   endtask : addr
endmodule : i2c_host_model

// file: verif/vib_regs_test.sv
`timescale 1ns/1ps
module vib_regs_test;
   import vib_regs_pkg::*;
   logic clk, nrst, run, scl, sda_host, sda_out, sda_oe, pos, neg, shut, ack;
   logic [7:0] d;
   monitor_t mon;
   drive_cfg_t cfg;
   int n_mismatch, checked;
   // open-drain wire: low when either side pulls
   wire sda_line = sda_host & (sda_oe ? sda_out : 1'b1);

   vib_regs u_dut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .monitor(mon), .motor_run_input(run), .motor_out_pos(pos),
      .motor_out_neg(neg), .drive_cfg(cfg), .thermal_shutdown(shut));
   i2c_host_model u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda_host));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task stop_test;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_clk
   task wr(input logic [7:0] p, input logic [7:0] v);
      u_host.start();
      u_host.addr(1'b0, ack);
      chk("address ack", ack, 10'h001);
      u_host.send(p, ack);
      u_host.send(v, ack);
      u_host.stop();
   endtask : wr
   // pointer set, repeated start, single byte read
   task rd(input logic [7:0] p);
      u_host.start();
      u_host.addr(1'b0, ack);
      u_host.send(p, ack);
      u_host.start();
      u_host.addr(1'b1, ack);
      u_host.recv(1'b0, d);
      u_host.stop();
   endtask : rd

   // motor follows the run pin with the bus left idle
   task test_idle_run;
      run = 1'b1;
      wait_clk(3);
      chk("motor on", {pos, neg}, 2'b11);
      run = 1'b0;
      wait_clk(3);
      chk("motor off", {pos, neg}, 2'b00);
   endtask : test_idle_run
   task test_defaults;
      chk("drive cfg", cfg, 10'h216);
      rd(8'h21);
      chk("drive setting", d, 8'h2C);
      rd(8'h22);
      chk("health flags", d, 8'h0E);
   endtask : test_defaults
   task test_fields;
      for (int c = 0; c < 8; c++) begin
         wr(8'h21, {c[2:0], c[2:0], 2'b11});
         rd(8'h21);
         chk("setting back", d, {c[2:0], c[2:0], 2'b00});
         chk("res select", cfg.input_res_select, c[2:0]);
         chk("level select", cfg.drive_level_select, c[2:0]);
         chk("level undef", cfg.level_undefined, c == 7);
      end
   endtask : test_fields
   // two-byte write runs into the read-only flags, then burst read
   task test_burst;
      u_host.start();
      u_host.addr(1'b0, ack);
      u_host.send(8'h21, ack);
      u_host.send(8'hA4, ack);
      u_host.send(8'h51, ack);
      u_host.start();
      u_host.addr(1'b1, ack);
      u_host.recv(1'b0, d);
      u_host.stop();
      chk("pointer after write", d, 8'h00);
      // a single read also steps the pointer, so the next read starts at 0x21
      rd(8'h20);
      chk("mode default", d, 8'h90);
      u_host.start();
      u_host.addr(1'b1, ack);
      u_host.recv(1'b1, d);
      chk("burst first", d, 8'hA4);
      u_host.recv(1'b0, d);
      chk("burst second", d, 8'h0E);
      u_host.stop();
   endtask : test_burst
   task test_bad_addr;
      u_host.start();
      u_host.send(8'h0E, ack);
      u_host.stop();
      chk("foreign address", ack, 10'h000);
   endtask : test_bad_addr
   // power-down and boost bits of the mode register
   task test_drive_mode;
      wr(8'h20, 8'h7F);
      rd(8'h20);
      chk("mode back", d, 8'h60);
      chk("boost cfg", {cfg.drive_enable, cfg.boost_drive_enable, cfg.boost_high_side}, 3'h3);
      run = 1'b1;
      wait_clk(3);
      chk("motor powered down", {pos, neg}, 2'h0);
      run = 1'b0;
      wr(8'h20, 8'h80);
      rd(8'h20);
      chk("mode restored", d, 8'h80);
   endtask : test_drive_mode
   task test_status;
      mon.supply_good = 1'b0;
      rd(8'h22);
      chk("supply flag", d, 8'h06);
      mon.supply_good = 1'b1;
      mon.reg_good = 1'b0;
      rd(8'h22);
      chk("regulator flag", d, 8'h0A);
      mon.reg_good = 1'b1;
      mon.temp_below_lo = 1'b0;
      mon.temp_above_hi = 1'b1;
      wait_clk(3);
      chk("shutdown set", shut, 10'h001);
      mon.temp_above_hi = 1'b0;
      run = 1'b1;
      rd(8'h22);
      chk("temp flag", d, 8'h0C);
      chk("motor in shutdown", pos, 10'h000);
      mon.temp_below_lo = 1'b1;
      wait_clk(3);
      chk("motor recovered", pos, 10'h001);
      run = 1'b0;
      rd(8'h21);
      chk("setting kept", d, 8'hA4);
   endtask : test_status

   // watchdog, far beyond the expected run length
   initial begin
      #800000;
      n_mismatch++;
      stop_test();
   end
   initial begin
      nrst = 1'b0;
      run = 1'b0;
      mon = '{1'b1, 1'b1, 1'b0, 1'b1};
      wait_clk(2);
      nrst = 1'b1;
      wait_clk(3);
      test_idle_run();
      test_defaults();
      test_fields();
      test_burst();
      test_drive_mode();
      test_bad_addr();
      test_status();
      stop_test();
   end
endmodule : vib_regs_test
